/* mpcc_pkg.sv */
/*
   Package of the motor PWM conduction-control block: register offsets,
   field positions, reset values, codes and the carrier types.
   Assumes a byte-addressed Wishbone bus with 32-bit data.
*/
package mpcc_pkg;

   ////////////////////////////////////////////////////////////////////////
   // Register map.
   localparam int          ADR_W    = 8;
   localparam int          DAT_W    = 32;
   localparam logic [7:0]  POT_OFS  = 8'h00;
   localparam logic [7:0]  OUT_OFS  = 8'h04;
   localparam logic [7:0]  SRC_OFS  = 8'h08;
   localparam logic [7:0]  ACT_OFS  = 8'h0C;

   ////////////////////////////////////////////////////////////////////////
   // Field positions.
   localparam int          UPPER_POLARITY_BIT = 3;
   localparam int          POLL_BIT = 2;
   localparam int          SYNC_LSB = 0;
   localparam int          SYNC_MSB = 1;
   localparam int          MODE_LSB = 8;
   localparam int          MODE_MSB = 10;
   localparam int          CTL_LSB  = 0;
   localparam int          CTL_MSB  = 5;
   localparam int          SRC_BIT  = 0;
   localparam int          N_PH     = 3;

   ////////////////////////////////////////////////////////////////////////
   // Transfer timing and control codes.
   localparam logic [1:0]  XFER_ASYNC = 2'h0;
   localparam logic [1:0]  XFER_ONE   = 2'h1;
   localparam logic [1:0]  XFER_PRD   = 2'h2;
   localparam logic [1:0]  XFER_BOTH  = 2'h3;
   localparam logic [1:0]  CTL_UP_LOW = 2'h1;
   localparam logic [1:0]  CTL_LO_LOW = 2'h2;
   localparam logic        SRC_BUS    = 1'h0;
   localparam int          CNT_ONE    = 1;

   ////////////////////////////////////////////////////////////////////////
   // Carrier types and reset values.
   typedef struct packed {
      logic [2:0] mode;
      logic [5:0] ctl;
   } mpcc_set_t;

   typedef struct packed {
      logic       pol_h;
      logic       pol_l;
      logic [1:0] sync;
   } mpcc_cfg_t;

   localparam mpcc_set_t   SET_RST  = 9'h000;
   localparam mpcc_cfg_t   CFG_RST  = 4'h0;
   localparam logic [2:0]  PORT_RST = 3'h7;

endpackage

/* mpcc_top.sv */
/*
   Conduction-control stage of a three-phase motor PWM unit, with its
   three configuration registers and a read-only active-settings register behind a classic Wishbone slave.
   Assumes the PWM counter, period, run enable and per-phase waveforms
   come from the compare stage on the same clock.
*/
`timescale 1ns/10ps

module mpcc_top #(
   parameter int CNT_W = 16
) (
   input  wire logic                     clk,
   input  wire logic                     resetn,
   input  wire logic [7:0]               adr_i,
   input  wire logic [31:0]              dat_i,
   input  wire logic                     we_i,
   input  wire logic [3:0]               sel_i,
   input  wire logic                     cyc_i,
   input  wire logic                     stb_i,
   output      logic                     ack_o,
   output      logic [31:0]              dat_o,
   input  wire logic [CNT_W-1:0]         pwm_cnt,
   input  wire logic [CNT_W-1:0]         pwm_period,
   input  wire logic                     pwm_run_enable,
   input  wire logic [2:0]               pwm_upper,
   input  wire logic [2:0]               pwm_lower,
   input  wire mpcc_pkg::mpcc_set_t      ve_settings,
   output      logic [2:0]               upper_out,
   output      logic [2:0]               lower_out,
   output      logic                     cfg_locked
);

   ////////////////////////////////////////////////////////////////////////
   // Parameter check.
   if (CNT_W < 2 || CNT_W > 32) begin : g_chk
      $error("CNT_W must lie between 2 and 32.");
   end

   ////////////////////////////////////////////////////////////////////////
   // Registers.
   mpcc_pkg::mpcc_cfg_t  cfg_reg;
   mpcc_pkg::mpcc_cfg_t  cfg_next;
   mpcc_pkg::mpcc_set_t  buf_reg;
   mpcc_pkg::mpcc_set_t  buf_next;
   mpcc_pkg::mpcc_set_t  act_reg;
   mpcc_pkg::mpcc_set_t  act_next;
   logic                 src_reg;
   logic                 src_next;
   logic                 ack_reg;
   logic [31:0]          dat_reg;
   logic [2:0]           up_reg;
   logic [2:0]           lo_reg;
   logic                 lock_reg;

   ////////////////////////////////////////////////////////////////////////
   // Bus decode.
   wire         wb_hit  = cyc_i & stb_i & ~ack_reg;
   wire         wb_wr   = wb_hit & we_i;
   wire         at_pot  = adr_i == mpcc_pkg::POT_OFS;
   wire         at_out  = adr_i == mpcc_pkg::OUT_OFS;
   wire         at_src  = adr_i == mpcc_pkg::SRC_OFS;
   wire         at_act  = adr_i == mpcc_pkg::ACT_OFS;
   wire         wr_pot  = wb_wr & at_pot & sel_i[0];
   wire         wr_lo   = wb_wr & at_out & sel_i[0];
   wire         wr_hi   = wb_wr & at_out & sel_i[1];
   wire         wr_src  = wb_wr & at_src & sel_i[0];

   ////////////////////////////////////////////////////////////////////////
   // Next values of the software registers; reserved bits are dropped.
   wire mpcc_pkg::mpcc_cfg_t cfg_wr = '{
      pol_h: dat_i[mpcc_pkg::UPPER_POLARITY_BIT],
      pol_l: dat_i[mpcc_pkg::POLL_BIT],
      sync:  dat_i[mpcc_pkg::SYNC_MSB:mpcc_pkg::SYNC_LSB]
   };
   // The polarity and timing are trusted to change only while stopped.
   assign cfg_next = wr_pot ? cfg_wr : cfg_reg;

   wire [2:0] mode_wr = wr_hi
      ? dat_i[mpcc_pkg::MODE_MSB:mpcc_pkg::MODE_LSB] : buf_reg.mode;
   wire [5:0] ctl_wr  = wr_lo
      ? dat_i[mpcc_pkg::CTL_MSB:mpcc_pkg::CTL_LSB] : buf_reg.ctl;
   assign buf_next = '{mode: mode_wr, ctl: ctl_wr};
   assign src_next = wr_src ? dat_i[mpcc_pkg::SRC_BIT] : src_reg;

   ////////////////////////////////////////////////////////////////////////
   // Transfer event and second buffer.
   wire cnt_one = pwm_cnt == CNT_W'(mpcc_pkg::CNT_ONE);
   wire cnt_prd = pwm_cnt == pwm_period;
   wire sel_one = cfg_reg.sync == mpcc_pkg::XFER_ONE
               || cfg_reg.sync == mpcc_pkg::XFER_BOTH;
   wire sel_prd = cfg_reg.sync == mpcc_pkg::XFER_PRD
               || cfg_reg.sync == mpcc_pkg::XFER_BOTH;
   wire xfer = cfg_reg.sync == mpcc_pkg::XFER_ASYNC
            || (sel_one && cnt_one)
            || (sel_prd && cnt_prd);
   // The bus source takes the value being written, so async is immediate.
   wire mpcc_pkg::mpcc_set_t src_set =
      (src_reg == mpcc_pkg::SRC_BUS) ? buf_next : ve_settings;
   assign act_next = xfer ? src_set : act_reg;

   ////////////////////////////////////////////////////////////////////////
   // Port mapping per phase.
   logic [2:0] up_next;
   logic [2:0] lo_next;
   for (genvar i = 0; i < mpcc_pkg::N_PH; i++) begin : g_ph
      wire       pm  = act_reg.mode[i];
      wire [1:0] ctl = act_reg.ctl[2*i +: 2];
      wire up_lvl = pm ? (ctl != mpcc_pkg::CTL_UP_LOW) & pwm_upper[i]
                       : ctl[1];
      wire lo_lvl = pm ? (ctl != mpcc_pkg::CTL_LO_LOW) & pwm_lower[i]
                       : ctl[0];
      assign up_next[i] = up_lvl ^ ~cfg_reg.pol_h;
      assign lo_next[i] = lo_lvl ^ ~cfg_reg.pol_l;
   end

   ////////////////////////////////////////////////////////////////////////
   // Read data; unmapped addresses and reserved bits read zero.
   wire [31:0] rd_pot = 32'(cfg_reg);
   wire [31:0] rd_out = {21'h000000, buf_reg.mode, 2'h0, buf_reg.ctl};
   wire [31:0] rd_act = {21'h000000, act_reg.mode, 2'h0, act_reg.ctl};
   wire [31:0] rd_src = 32'(src_reg);
   wire [31:0] rd_data = at_pot ? rd_pot
                       : at_out ? rd_out
                       : at_src ? rd_src
                       : at_act ? rd_act
                       : 32'h00000000;

   ////////////////////////////////////////////////////////////////////////
   // Flip-flops.
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         cfg_reg <= mpcc_pkg::CFG_RST;
         buf_reg <= mpcc_pkg::SET_RST;
         act_reg <= mpcc_pkg::SET_RST;
         src_reg <= mpcc_pkg::SRC_BUS;
      end else begin
         cfg_reg <= cfg_next;
         buf_reg <= buf_next;
         act_reg <= act_next;
         src_reg <= src_next;
      end
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         ack_reg  <= 1'h0;
         dat_reg  <= 32'h00000000;
         lock_reg <= 1'h0;
      end else begin
         ack_reg  <= wb_hit;
         dat_reg  <= wb_hit ? rd_data : 32'h00000000;
         lock_reg <= pwm_run_enable;
      end
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         up_reg <= mpcc_pkg::PORT_RST;
         lo_reg <= mpcc_pkg::PORT_RST;
      end else begin
         up_reg <= up_next;
         lo_reg <= lo_next;
      end
   end

   assign ack_o      = ack_reg;
   assign dat_o      = dat_reg;
   assign upper_out  = up_reg;
   assign lower_out  = lo_reg;
   assign cfg_locked = lock_reg;

   ////////////////////////////////////////////////////////////////////////
   // Checks.
   default clocking cb @(posedge clk); endclocking
   default disable iff (!resetn);

   upper_pol_low_a: assert property (
      !cfg_reg.pol_h && !act_reg.mode[0]
      |=> upper_out[0] == !$past(act_reg.ctl[1]))
      else $error("Active-low upper fixed level not inverted.");

   lower_pol_high_a: assert property (
      cfg_reg.pol_l && !act_reg.mode[0]
      |=> lower_out[0] == $past(act_reg.ctl[0]))
      else $error("Active-high lower fixed level wrong.");

   xfer_hold_a: assert property (
      cfg_reg.sync == mpcc_pkg::XFER_ONE && !cnt_one
      |=> act_reg == $past(act_reg))
      else $error("Settings moved without a count-one event.");

   async_bus_a: assert property (
      cfg_reg.sync == mpcc_pkg::XFER_ASYNC && !src_reg
      |=> act_reg == buf_reg)
      else $error("Async transfer did not follow the bus buffer.");

   sequence ve_load_s;
      src_reg && xfer;
   endsequence
   ve_load_a: assert property (
      ve_load_s |=> act_reg == $past(ve_settings))
      else $error("Vector engine settings not transferred.");

   ve_blocks_bus_a: assert property (
      src_reg && wr_lo && xfer |=> act_reg == $past(ve_settings))
      else $error("Bus write leaked into the second buffer.");

   pwm_cut_upper_a: assert property (
      cfg_reg.pol_h && act_reg.mode[0]
      && act_reg.ctl[1:0] == mpcc_pkg::CTL_UP_LOW
      |=> !upper_out[0])
      else $error("Upper output not held low for code 01.");

   sequence pwm_pass_s;
      act_reg.mode[0] && act_reg.ctl[1:0] != mpcc_pkg::CTL_UP_LOW
      && act_reg.ctl[1:0] != mpcc_pkg::CTL_LO_LOW;
   endsequence
   pwm_pass_a: assert property (
      pwm_pass_s and !cfg_reg.pol_l
      |=> lower_out[0] == !$past(pwm_lower[0]))
      else $error("Lower PWM not passed in PWM mode.");

   reserved_zero_a: assert property (
      wb_hit && !we_i && at_pot
      |=> ack_o && dat_o[31:4] == 28'h0000000)
      else $error("Reserved bits did not read zero.");

   upper_pol_high_a: assert property (
      cfg_reg.pol_h && !act_reg.mode[0]
      |=> upper_out[0] == $past(act_reg.ctl[1]))
      else $error("Active-high upper fixed level wrong.");

   lower_pol_low_a: assert property (
      !cfg_reg.pol_l && !act_reg.mode[0]
      |=> lower_out[0] == !$past(act_reg.ctl[0]))
      else $error("Active-low lower fixed level not inverted.");

   xfer_prd_hold_a: assert property (
      cfg_reg.sync == mpcc_pkg::XFER_PRD && !cnt_prd
      |=> act_reg == $past(act_reg))
      else $error("Settings moved without a period event.");

   xfer_one_load_a: assert property (
      cfg_reg.sync == mpcc_pkg::XFER_ONE && cnt_one && !src_reg
      |=> act_reg == buf_reg)
      else $error("Count-one event did not move the settings.");

   xfer_both_load_a: assert property (
      cfg_reg.sync == mpcc_pkg::XFER_BOTH && (cnt_one || cnt_prd) && !src_reg
      |=> act_reg == buf_reg)
      else $error("Either-event transfer did not move the settings.");

   async_write_a: assert property (
      cfg_reg.sync == mpcc_pkg::XFER_ASYNC && !src_reg && wr_lo
      |=> act_reg.ctl == $past(dat_i[mpcc_pkg::CTL_MSB:mpcc_pkg::CTL_LSB]))
      else $error("Async write did not reach the active settings.");

   settings_hold_a: assert property (
      !xfer
      |=> act_reg == $past(act_reg))
      else $error("Active settings changed without a transfer.");

   fixed_w_a: assert property (
      cfg_reg.pol_h && cfg_reg.pol_l && !act_reg.mode[2]
      |=> {upper_out[2], lower_out[2]} == $past(act_reg.ctl[5:4]))
      else $error("Fixed W phase levels wrong.");

   pwm_cut_lower_a: assert property (
      cfg_reg.pol_l && act_reg.mode[1]
      && act_reg.ctl[3:2] == mpcc_pkg::CTL_LO_LOW
      |=> !lower_out[1])
      else $error("Lower output not held low for code 10.");

   pwm_inv_upper_a: assert property (
      !cfg_reg.pol_h && act_reg.mode[0]
      && act_reg.ctl[1:0] == mpcc_pkg::CTL_UP_LOW
      |=> upper_out[0])
      else $error("Active-low upper level not inverted for code 01.");

   unmapped_read_a: assert property (
      wb_hit && !we_i && !(at_pot || at_out || at_src || at_act)
      |=> ack_o && dat_o == 32'h00000000)
      else $error("Unmapped address did not read zero.");

   reserved_out_a: assert property (
      wb_hit && !we_i && at_out
      |=> dat_o[31:11] == 21'h000000 && dat_o[7:6] == 2'h0)
      else $error("Reserved output-control bits did not read zero.");

endmodule

/* mpcc_gate_model.sv */
/*
   Behavioural model of the inverter gate drivers that sit on the six
   port lines of the conduction-control block.
   Assumes the port lines are sampled on the block's own clock.
*/
`timescale 1ns/10ps

module mpcc_gate_model (
   input  wire logic       clk,
   input  wire logic       resetn,
   input  wire logic [2:0] upper_out,
   input  wire logic [2:0] lower_out,
   output      logic [5:0] gate_lvl
);
   // Latches the levels that the drivers see on each rising edge.
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) gate_lvl <= 6'h3F;
      else gate_lvl <= {upper_out, lower_out};
   end
endmodule

/* testbench.sv */
/*
   Self-checking bench of the conduction-control block: Wishbone register
   accesses and checks of the six port lines.
   Assumes the gate driver model and the design package are compiled first.
*/
`timescale 1ns/10ps

module testbench;
   logic                clk, resetn, we_i, cyc_i, stb_i, pwm_run_enable, ack_o, cfg_locked;
   logic [7:0]          adr_i;
   logic [31:0]         dat_i, dat_o, rd;
   logic [3:0]          sel_i;
   logic [15:0]         pwm_cnt, pwm_period;
   logic [2:0]          pwm_upper, pwm_lower, upper_out, lower_out;
   logic [5:0]          gate_lvl;
   mpcc_pkg::mpcc_set_t ve_settings;
   int                  errors, n_checks;

   mpcc_top mpcc_top_i (.clk(clk), .resetn(resetn), .adr_i(adr_i), .dat_i(dat_i),
      .we_i(we_i), .sel_i(sel_i), .cyc_i(cyc_i), .stb_i(stb_i), .ack_o(ack_o),
      .dat_o(dat_o), .pwm_cnt(pwm_cnt), .pwm_period(pwm_period),
      .pwm_run_enable(pwm_run_enable), .pwm_upper(pwm_upper), .pwm_lower(pwm_lower),
      .ve_settings(ve_settings), .upper_out(upper_out), .lower_out(lower_out),
      .cfg_locked(cfg_locked));
   mpcc_gate_model mpcc_gate_model_i (.clk(clk), .resetn(resetn), .upper_out(upper_out),
      .lower_out(lower_out), .gate_lvl(gate_lvl));

   ////////////////////////////////////////////////////////////////////////
   // Bus and compare tasks.
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      cyc_i <= 1'h1;
      stb_i <= 1'h1;
      we_i  <= w;
      adr_i <= a;
      dat_i <= d;
      sel_i <= 4'hF;
      do @(posedge clk); while (ack_o !== 1'h1);
      rd = dat_o;
      cyc_i <= 1'h0;
      stb_i <= 1'h0;
      we_i  <= 1'h0;
   endtask

   task automatic chk32(input logic [31:0] exp);
      n_checks++;
      if (rd !== exp) begin
         errors++;
         $display("wrong value at %0t: read %h expected %h", $time, rd, exp);
      end
   endtask

   task automatic ports(input logic [2:0] eu, input logic [2:0] el);
      repeat (4) @(posedge clk);
      n_checks++;
      if (upper_out !== eu || lower_out !== el || gate_lvl !== {eu, el}) begin
         errors++;
         $display("wrong value at %0t: ports %h %h gates %h expected %h %h", $time,
                  upper_out, lower_out, gate_lvl, eu, el);
      end
   endtask

   task automatic flag(input logic e);
      repeat (2) @(posedge clk);
      n_checks++;
      if (cfg_locked !== e) begin
         errors++;
         $display("wrong value at %0t: lock flag %b expected %b", $time, cfg_locked, e);
      end
   endtask

   task results;
      if (errors == 0 && n_checks > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask

   ////////////////////////////////////////////////////////////////////////
   // Clock, watchdog and tests.
   initial begin
      clk = 1'h0;
      forever #10 clk = ~clk;
   end

   initial begin
      #100000;
      errors++;
      results();
   end

   initial begin
      resetn = 1'h0; we_i = 1'h0; cyc_i = 1'h0; stb_i = 1'h0; pwm_run_enable = 1'h0;
      adr_i = 8'h00; dat_i = 32'h0; sel_i = 4'h0; pwm_cnt = 16'h0005; pwm_period = 16'h0009;
      pwm_upper = 3'h7; pwm_lower = 3'h7; ve_settings = 9'h000; errors = 0; n_checks = 0;
      repeat (5) @(posedge clk);
      resetn <= 1'h1;
      ports(3'h7, 3'h7);
      flag(1'h0);
      wb(1'h0, mpcc_pkg::POT_OFS, 32'h0);
      chk32(32'h0);
      wb(1'h0, mpcc_pkg::OUT_OFS, 32'h0);
      chk32(32'h0);
      wb(1'h1, mpcc_pkg::POT_OFS, 32'hFFFFFFFF);
      wb(1'h0, mpcc_pkg::POT_OFS, 32'h0);
      chk32(32'h0000000F);
      wb(1'h1, mpcc_pkg::OUT_OFS, 32'hFFFFFFFF);
      wb(1'h0, mpcc_pkg::OUT_OFS, 32'h0);
      chk32(32'h0000073F);
      wb(1'h0, 8'h10, 32'h0);
      chk32(32'h0);
      wb(1'h1, mpcc_pkg::POT_OFS, 32'h0000000C);
      wb(1'h1, mpcc_pkg::OUT_OFS, 32'h00000036);
      ports(3'h5, 3'h6);
      wb(1'h0, mpcc_pkg::ACT_OFS, 32'h0);
      chk32(32'h00000036);
      wb(1'h1, mpcc_pkg::POT_OFS, 32'h00000008);
      ports(3'h5, 3'h1);
      wb(1'h1, mpcc_pkg::POT_OFS, 32'h00000004);
      ports(3'h2, 3'h6);
      wb(1'h1, mpcc_pkg::POT_OFS, 32'h0000000C);
      wb(1'h1, mpcc_pkg::OUT_OFS, 32'h00000739);
      ports(3'h6, 3'h5);
      pwm_upper <= 3'h2;
      pwm_lower <= 3'h4;
      ports(3'h2, 3'h4);
      wb(1'h1, mpcc_pkg::POT_OFS, 32'h00000000);
      ports(3'h5, 3'h3);
      wb(1'h1, mpcc_pkg::POT_OFS, 32'h00000008);
      wb(1'h1, mpcc_pkg::OUT_OFS, 32'h00000700);
      ports(3'h2, 3'h3);
      wb(1'h1, mpcc_pkg::POT_OFS, 32'h0000000C);
      wb(1'h1, mpcc_pkg::OUT_OFS, 32'h00000000);
      ports(3'h0, 3'h0);
      for (int t = 1; t < 4; t++) begin
         wb(1'h1, mpcc_pkg::POT_OFS, {28'h0000000, 2'h3, t[1:0]});
         wb(1'h1, mpcc_pkg::OUT_OFS, t[0] ? 32'h0000003F : 32'h00000000);
         ports(t[0] ? 3'h0 : 3'h7, t[0] ? 3'h0 : 3'h7);
         pwm_cnt <= (t == 1) ? 16'h0001 : 16'h0009;
         ports(t[0] ? 3'h7 : 3'h0, t[0] ? 3'h7 : 3'h0);
         @(posedge clk);
         pwm_cnt <= 16'h0005;
      end
      wb(1'h1, mpcc_pkg::POT_OFS, 32'h0000000C);
      wb(1'h1, mpcc_pkg::SRC_OFS, 32'h00000001);
      ve_settings <= 9'h015;
      wb(1'h1, mpcc_pkg::OUT_OFS, 32'h0000003F);
      ports(3'h0, 3'h7);
      wb(1'h0, mpcc_pkg::ACT_OFS, 32'h0);
      chk32(32'h00000015);
      wb(1'h0, mpcc_pkg::OUT_OFS, 32'h0);
      chk32(32'h0000003F);
      pwm_run_enable <= 1'h1;
      flag(1'h1);
      pwm_run_enable <= 1'h0;
      flag(1'h0);
      results();
   end
endmodule
